// file: atuc_pkg.sv
// Purpose: Shared constants for the acquisition trigger and update control block
// Assumes: 32-bit APB, one word per register, byte addresses
// Notes: All offsets, field positions and the cmd, interval, count and DAC reset values live here
`default_nettype none
package atuc_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ATUC_OFS_CMD = 8'h00;
	localparam logic [7:0] ATUC_OFS_INTERVAL = 8'h04;
	localparam logic [7:0] ATUC_OFS_COUNT = 8'h08;
	localparam logic [7:0] ATUC_OFS_STATUS = 8'h0C;
	localparam logic [7:0] ATUC_OFS_MASK = 8'h10;
	localparam logic [7:0] ATUC_OFS_TMR_CLR = 8'h14;
	localparam logic [7:0] ATUC_OFS_DAC0 = 8'h18;
	localparam logic [7:0] ATUC_OFS_DAC1 = 8'h1C;
	localparam logic [7:0] ATUC_OFS_ARM = 8'h20;
	// ==========================================================
	// Command register fields
	localparam int ATUC_CMD_POSTTRIG = 0;
	localparam int ATUC_CMD_PRETRIGGER_SELECT = 1;
	localparam int ATUC_CMD_EXT_CONVERT_N_EN = 2;
	localparam int ATUC_CMD_CONTROLLED = 3;
	localparam int ATUC_CMD_SW_CONV_EN = 4;
	localparam int ATUC_CMD_DAC0_LD = 5;
	localparam int ATUC_CMD_DAC1_LD = 6;
	localparam int ATUC_CMD_CNT_IRQ_EN = 7;
	localparam int ATUC_CMD_WIDTH = 8;
	localparam logic [ATUC_CMD_WIDTH-1:0] ATUC_CMD_RESET = 8'h00;
	// ==========================================================
	// Status fields (sticky, write one to clear, except live bits)
	localparam int ATUC_ST_CNT_IRQ = 0;
	localparam int ATUC_ST_CONVERT = 1;
	localparam int ATUC_ST_TRIG = 2;
	localparam int ATUC_ST_DONE = 3;
	localparam int ATUC_ST_EVENTS = 4;
	localparam int ATUC_ST_ARMED = 8;
	localparam int ATUC_ST_RUNNING = 9;
	localparam int ATUC_ST_GATED = 10;
	// ==========================================================
	// Widths and reset values
	localparam int ATUC_CNT_WIDTH = 16;
	localparam int ATUC_DAC_WIDTH = 12;
	localparam logic [15:0] ATUC_CNT_RESET = 16'h0000;
	localparam logic [15:0] ATUC_INTERVAL_RESET = 16'h0001;
	localparam logic [11:0] ATUC_DAC_RESET = 12'h000;
	// ==========================================================
	// Sequence states
	typedef enum logic [1:0] {
		ATUC_IDLE = 2'b00,
		ATUC_ARMED = 2'b01,
		ATUC_RUN = 2'b10,
		ATUC_DONE = 2'b11
	} atuc_state_e;
endpackage
`default_nettype wire

// file: atuc_sync_edge.sv
// Purpose: Two-stage synchroniser with rise and fall detection
// Assumes: Input is asynchronous to mclk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module atuc_sync_edge (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Asynchronous input
	input wire logic async_in,
	// Synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic stage1;
	logic stage2;
	logic stage3;

	// ==========================================================
	// Synchroniser
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
		end else begin
			stage1 <= async_in; // [R18]
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise = stage2 & ~stage3;
	assign fall = ~stage2 & stage3;
endmodule
`default_nettype wire

// file: atuc_top.sv
// Purpose: External convert, trigger and DAC update control with APB registers
// Assumes: External pins asynchronous to mclk; mclk 100 MHz
// Notes: Interval counter paces conversions; sample counter ends controlled runs
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: Each convert falling edge starts one conversion
// R02: Counter 0 paces, counter 1 counts samples
// R03: Posttrigger holds interval counter until trigger rise
// R04: Posttrigger convert enabled at next convert rise
// R05: Trigger while convert high costs one falling edge
// R06: Later trigger edges ignored until re-armed
// R07: Controlled mode stops after programmed count
// R08: Sample counter loads late, two extra conversions
// R09: Trigger also starts free-running acquisition
// R10: Pretrigger converts early, sample counter gated
// R11: Pretrigger only with controlled mode, 65535 max
// R12: No select bit means trigger ignored
// R13: Load enable updates DAC while update low
// R14: DAC write during low update shows immediately
// R15: Every update rise sets counter flag
// R16: Enabled counter flag raises interrupt
// R17: Any timer clear write clears counter flag
// R18: Convert, trigger, update pass two flip-flops
// R19: New sequence re-arms trigger detector
module atuc_top
	import atuc_pkg::*;
#(
	parameter int CNT_WIDTH = ATUC_CNT_WIDTH,
	parameter int DAC_WIDTH = ATUC_DAC_WIDTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External pins
	input wire logic ext_convert_n,
	input wire logic ext_acq_trigger,
	input wire logic ext_dac_update_n,
	// Converter side
	output logic adc_convert,
	output logic [DAC_WIDTH-1:0] dac0_out,
	output logic [DAC_WIDTH-1:0] dac1_out,
	// Interrupt
	output logic irq
);
	logic [ATUC_CMD_WIDTH-1:0] cmd;
	logic [CNT_WIDTH-1:0] interval_load;
	logic [CNT_WIDTH-1:0] count_load;
	logic [CNT_WIDTH-1:0] sample_interval_counter;
	logic [CNT_WIDTH-1:0] sample_count_counter;
	logic [DAC_WIDTH-1:0] dac0_data;
	logic [DAC_WIDTH-1:0] dac1_data;
	logic [ATUC_ST_EVENTS-1:0] status;
	logic [ATUC_ST_EVENTS-1:0] mask;
	logic [ATUC_ST_EVENTS-1:0] ev;
	atuc_state_e state;
	logic conv_level, conv_rise, conv_fall;
	logic trig_level, trig_rise, trig_fall;
	logic upd_level, upd_rise, upd_fall;
	logic wr_en, rd_en, arm_wr, clr_wr;
	logic posttrigger_select, pretrigger_select;
	logic dac0_ext_load_en, dac1_ext_load_en;
	logic counter_irq_enable, counter_irq_flag;
	logic controlled, ext_conv_en, sw_conv_en;
	logic ext_conv_live;
	logic interval_gate;
	logic interval_tick;
	logic count_gate;
	logic count_loaded;
	logic count_clk_seen;
	logic count_expired;
	logic conv_ok;
	logic next_convert;
	logic addr_ok;

	// ==========================================================
	// Input synchronisers
	atuc_sync_edge u_conv (.mclk(mclk), .reset_n(reset_n), .async_in(ext_convert_n),
		.level(conv_level), .rise(conv_rise), .fall(conv_fall)); // [R18]
	atuc_sync_edge u_trig (.mclk(mclk), .reset_n(reset_n), .async_in(ext_acq_trigger),
		.level(trig_level), .rise(trig_rise), .fall(trig_fall)); // [R18]
	atuc_sync_edge u_upd (.mclk(mclk), .reset_n(reset_n), .async_in(ext_dac_update_n),
		.level(upd_level), .rise(upd_rise), .fall(upd_fall)); // [R18]

	// ==========================================================
	// Command fields
	assign posttrigger_select = cmd[ATUC_CMD_POSTTRIG];
	assign pretrigger_select = cmd[ATUC_CMD_PRETRIGGER_SELECT];
	assign ext_conv_en = cmd[ATUC_CMD_EXT_CONVERT_N_EN];
	assign controlled = cmd[ATUC_CMD_CONTROLLED];
	assign sw_conv_en = cmd[ATUC_CMD_SW_CONV_EN];
	assign dac0_ext_load_en = cmd[ATUC_CMD_DAC0_LD];
	assign dac1_ext_load_en = cmd[ATUC_CMD_DAC1_LD];
	assign counter_irq_enable = cmd[ATUC_CMD_CNT_IRQ_EN];
	assign counter_irq_flag = status[ATUC_ST_CNT_IRQ];

	// ==========================================================
	// APB decode; every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign arm_wr = wr_en & (paddr == ATUC_OFS_ARM);
	assign clr_wr = wr_en & (paddr == ATUC_OFS_TMR_CLR);
	always_comb begin
		case (paddr)
			ATUC_OFS_CMD, ATUC_OFS_INTERVAL, ATUC_OFS_COUNT, ATUC_OFS_STATUS,
			ATUC_OFS_MASK, ATUC_OFS_TMR_CLR, ATUC_OFS_DAC0, ATUC_OFS_DAC1,
			ATUC_OFS_ARM: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd <= ATUC_CMD_RESET;
			interval_load <= CNT_WIDTH'(ATUC_INTERVAL_RESET);
			count_load <= CNT_WIDTH'(ATUC_CNT_RESET);
			mask <= '0;
			dac0_data <= DAC_WIDTH'(ATUC_DAC_RESET);
			dac1_data <= DAC_WIDTH'(ATUC_DAC_RESET);
		end else if (wr_en) begin
			case (paddr)
				ATUC_OFS_CMD: cmd <= pwdata[ATUC_CMD_WIDTH-1:0];
				ATUC_OFS_INTERVAL: interval_load <= pwdata[CNT_WIDTH-1:0];
				ATUC_OFS_COUNT: count_load <= pwdata[CNT_WIDTH-1:0];
				ATUC_OFS_MASK: mask <= pwdata[ATUC_ST_EVENTS-1:0];
				ATUC_OFS_DAC0: dac0_data <= pwdata[DAC_WIDTH-1:0];
				ATUC_OFS_DAC1: dac1_data <= pwdata[DAC_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= '0;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				ATUC_OFS_CMD: prdata <= 32'(cmd);
				ATUC_OFS_INTERVAL: prdata <= 32'(sample_interval_counter);
				ATUC_OFS_COUNT: prdata <= 32'(sample_count_counter);
				ATUC_OFS_STATUS: begin
					prdata <= 32'(status);
					prdata[ATUC_ST_ARMED] <= (state == ATUC_ARMED);
					prdata[ATUC_ST_RUNNING] <= (state == ATUC_RUN);
					prdata[ATUC_ST_GATED] <= count_gate;
				end
				ATUC_OFS_MASK: prdata <= 32'(mask);
				ATUC_OFS_DAC0: prdata <= 32'(dac0_data);
				ATUC_OFS_DAC1: prdata <= 32'(dac1_data);
				default: prdata <= '0;
			endcase
		end
	end

	// ==========================================================
	// Sequence state: arming writes start a new sequence
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ATUC_IDLE;
		end else begin
			case (state)
				ATUC_IDLE: if (arm_wr) begin
					state <= ATUC_ARMED; // [R19]
				end
				ATUC_ARMED: if (arm_wr) begin
					state <= ATUC_ARMED;
				end else if (trig_rise & (posttrigger_select ^ pretrigger_select)) begin
					state <= ATUC_RUN; // [R03] [R09] [R12]
				end else if (~posttrigger_select & ~pretrigger_select) begin
					state <= ATUC_RUN; // [R12]
				end
				ATUC_RUN: if (arm_wr) begin
					state <= ATUC_ARMED; // [R19]
				end else if (count_expired & controlled) begin
					state <= ATUC_DONE; // [R07]
				end
				ATUC_DONE: if (arm_wr) begin
					state <= ATUC_ARMED; // [R19]
				end
				default: state <= ATUC_IDLE;
			endcase
		end
	end
	// Trigger edges outside ARMED are simply not looked at [R06]

	// ==========================================================
	// External convert enable: posttrigger waits for a convert rise
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ext_conv_live <= 1'b0;
		end else if (arm_wr) begin
			ext_conv_live <= pretrigger_select & ext_conv_en; // [R10]
		end else if (state == ATUC_RUN && ext_conv_en && conv_rise) begin
			ext_conv_live <= 1'b1; // [R04] [R05]
		end else if (state == ATUC_RUN && ext_conv_en && !posttrigger_select) begin
			// Only posttrigger waits for a rise; otherwise the very first fall must count
			ext_conv_live <= 1'b1; // [R01] [R12]
		end else if (state == ATUC_DONE) begin
			ext_conv_live <= 1'b0;
		end
	end

	// ==========================================================
	// Counter 0: sample interval, gated off until trigger in posttrigger mode
	assign interval_gate = (state == ATUC_RUN) |
		((state == ATUC_ARMED) & pretrigger_select & sw_conv_en); // [R02] [R03] [R10]
	assign interval_tick = interval_gate & sw_conv_en &
		(sample_interval_counter == CNT_WIDTH'(1));
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sample_interval_counter <= CNT_WIDTH'(ATUC_INTERVAL_RESET);
		end else if (arm_wr || !interval_gate || interval_tick) begin
			sample_interval_counter <= interval_load; // [R02]
		end else begin
			sample_interval_counter <= sample_interval_counter - CNT_WIDTH'(1);
		end
	end

	// ==========================================================
	// Conversion strobe
	assign conv_ok = ~(controlled & count_expired); // [R07] [R11]
	assign next_convert = conv_ok & (interval_tick | (ext_conv_live & conv_fall)); // [R01]
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			adc_convert <= 1'b0;
		end else begin
			adc_convert <= next_convert;
		end
	end

	// ==========================================================
	// Counter 1: sample count, clocked by conversions; loads late
	assign count_gate = (state == ATUC_RUN); // [R10]
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sample_count_counter <= CNT_WIDTH'(ATUC_CNT_RESET);
			count_loaded <= 1'b0;
			count_clk_seen <= 1'b0;
			count_expired <= 1'b0;
		end else if (arm_wr) begin
			count_loaded <= 1'b0;
			count_clk_seen <= 1'b0;
			count_expired <= 1'b0;
		end else if (count_gate && next_convert) begin
			// First pulse is the clock rise, second its fall: both pass uncounted
			if (!count_clk_seen) begin
				count_clk_seen <= 1'b1; // [R08]
			end else if (!count_loaded) begin
				sample_count_counter <= count_load; // [R08]
				count_loaded <= 1'b1;
			end else if (sample_count_counter <= CNT_WIDTH'(1)) begin
				sample_count_counter <= '0;
				count_expired <= 1'b1; // [R07]
			end else begin
				sample_count_counter <= sample_count_counter - CNT_WIDTH'(1);
			end
		end
	end

	// ==========================================================
	// DAC outputs: level-sensitive transparent update while update is low
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dac0_out <= DAC_WIDTH'(ATUC_DAC_RESET);
			dac1_out <= DAC_WIDTH'(ATUC_DAC_RESET);
		end else begin
			if (dac0_ext_load_en && !upd_level) begin
				dac0_out <= dac0_data; // [R13] [R14]
			end
			if (dac1_ext_load_en && !upd_level) begin
				dac1_out <= dac1_data; // [R13] [R14]
			end
		end
	end

	// ==========================================================
	// Sticky status; set wins over clear
	assign ev[ATUC_ST_CNT_IRQ] = upd_rise; // [R15]
	assign ev[ATUC_ST_CONVERT] = next_convert;
	assign ev[ATUC_ST_TRIG] = (state == ATUC_ARMED) & trig_rise &
		(posttrigger_select ^ pretrigger_select);
	assign ev[ATUC_ST_DONE] = (state == ATUC_RUN) & count_expired & controlled;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status <= '0;
		end else begin
			for (int i = 0; i < ATUC_ST_EVENTS; i++) begin
				if (ev[i]) begin
					status[i] <= 1'b1; // [R15]
				end else if (wr_en && paddr == ATUC_OFS_STATUS && pwdata[i]) begin
					status[i] <= 1'b0;
				end else if (i == ATUC_ST_CNT_IRQ && clr_wr) begin
					status[i] <= 1'b0; // [R17]
				end
			end
		end
	end

	// Counter flag needs its own enable as well as the mask bit
	assign irq = (counter_irq_flag & counter_irq_enable & mask[ATUC_ST_CNT_IRQ]) |
		|(status[ATUC_ST_EVENTS-1:1] & mask[ATUC_ST_EVENTS-1:1]); // [R16]

	logic unused_ok;
	assign unused_ok = &{1'b0, rd_en, conv_level, trig_level, trig_fall, upd_fall, pwdata};
endmodule
`default_nettype wire

// file: atuc_checker.sv
// Purpose: Port-level checks for the trigger and update control block
// Assumes: Software-paced conversions stay disabled while checking
// Notes: Quiet counters bound how long an output may lag its cause
`timescale 1ns/1ps
`default_nettype none
module atuc_checker #(
	parameter int DAC_WIDTH = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic ext_convert_n,
	input wire logic ext_acq_trigger,
	input wire logic ext_dac_update_n,
	// Outputs
	input wire logic adc_convert,
	input wire logic [DAC_WIDTH-1:0] dac0_out,
	input wire logic [DAC_WIDTH-1:0] dac1_out,
	input wire logic irq
);
	// ==========================================================
	// Quiet counters: cycles since the last possible cause
	logic [3:0] q_dac;
	logic [3:0] q_irq;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			q_dac <= 4'h0;
		else if (psel || !ext_dac_update_n)
			q_dac <= 4'h0;
		else if (q_dac != 4'hF)
			q_dac <= q_dac + 4'h1;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			q_irq <= 4'h0;
		else if (psel || $changed({ext_convert_n, ext_acq_trigger, ext_dac_update_n}))
			q_irq <= 4'h0;
		else if (q_irq != 4'hF)
			q_irq <= q_irq + 4'h1;
	end
	// ==========================================================
	// Properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_convert_single: assert property (adc_convert |=> !adc_convert)
		else $error("convert pulse longer than one cycle");
	a_convert_from_pin: assert property (adc_convert |-> !$past(ext_convert_n, 2))
		else $error("convert without a low convert pin");
	a_convert_sync_lag: assert property ($fell(ext_convert_n) |-> !adc_convert [*3])
		else $error("convert faster than the synchroniser allows");
	a_dac_quiet_hold: assert property (q_dac >= 4'h6 |-> $stable(dac0_out) && $stable(dac1_out))
		else $error("dac output moved with update high and no write");
	a_irq_quiet_hold: assert property (q_irq == 4'hF |-> $stable(irq))
		else $error("irq moved with no pin event or write");
	a_pready_high: assert property (pready)
		else $error("pready low");
	a_slverr_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_prdata_setup_load: assert property ($changed(prdata) |-> $past(psel && !penable))
		else $error("read data changed outside a setup cycle");
	c_convert: cover property (adc_convert);
	c_irq_rise: cover property ($rose(irq));
	c_slverr: cover property (pslverr);
endmodule
bind atuc_top atuc_checker #(.DAC_WIDTH(DAC_WIDTH)) i_atuc_checker (
	.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_convert_n(ext_convert_n), .ext_acq_trigger(ext_acq_trigger),
	.ext_dac_update_n(ext_dac_update_n), .adc_convert(adc_convert),
	.dac0_out(dac0_out), .dac1_out(dac1_out), .irq(irq));
`default_nettype wire

// file: atuc_pins_model.sv
// Purpose: Behavioural sources for the convert, trigger and update pins
// Assumes: Convert and update idle high, trigger idles low
// Notes: Each level holds at least nine cycles so the synchronisers always see it
`timescale 1ns/1ps
`default_nettype none
module atuc_pins_model (
	// Clock
	input wire logic mclk,
	// Pins
	output logic ext_convert_n,
	output logic ext_acq_trigger,
	output logic ext_dac_update_n
);
	initial begin
		ext_convert_n = 1'b1;
		ext_acq_trigger = 1'b0;
		ext_dac_update_n = 1'b1;
	end
	// ==========================================================
	// Level drivers
	task automatic drive_conv(input logic v);
		@(posedge mclk);
		ext_convert_n <= v;
		repeat (8) @(posedge mclk);
	endtask
	task automatic drive_trig(input logic v);
		@(posedge mclk);
		ext_acq_trigger <= v;
		repeat (8) @(posedge mclk);
	endtask
	task automatic drive_upd(input logic v);
		@(posedge mclk);
		ext_dac_update_n <= v;
		repeat (8) @(posedge mclk);
	endtask
	task automatic conv_pulses(input int n);
		repeat (n) begin
			drive_conv(1'b0);
			drive_conv(1'b1);
		end
	endtask
endmodule
`default_nettype wire

// file: atuc_tb_top.sv
// Purpose: Self-checking bench for trigger, convert and DAC update control
// Assumes: Zero-wait APB slave, pins driven by the partner model
// Notes: Conversion counts are taken from adc_convert pulses
`timescale 1ns/1ps
`default_nettype none
module atuc_tb_top import atuc_pkg::*;;
	logic mclk;
	logic reset_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, adc_convert, irq, errv;
	logic [11:0] dac0_out, dac1_out;
	logic ext_convert_n, ext_acq_trigger, ext_dac_update_n;
	logic [31:0] rdv;
	int err_total = 0;
	int samples_checked = 0;
	int conv_n = 0;
	int base;
	// Mode table: post high, post low, free run, pretrigger, no select
	logic [7:0] m_cmd [5] = '{8'h0D, 8'h0D, 8'h05, 8'h0E, 8'h0C};
	int m_cnt [5] = '{3, 3, 3, 2, 2};
	int m_pre [5] = '{2, 2, 2, 3, 3};
	int e_pre [5] = '{0, 0, 0, 3, 3};
	int e_post [5] = '{5, 5, 7, 4, 1};
	bit m_low [5] = '{0, 1, 0, 0, 0};
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (adc_convert === 1'b1) conv_n++;
	atuc_top i_atuc_top (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_convert_n(ext_convert_n), .ext_acq_trigger(ext_acq_trigger),
		.ext_dac_update_n(ext_dac_update_n), .adc_convert(adc_convert),
		.dac0_out(dac0_out), .dac1_out(dac1_out), .irq(irq));
	atuc_pins_model i_atuc_pins_model (.mclk(mclk), .ext_convert_n(ext_convert_n),
		.ext_acq_trigger(ext_acq_trigger), .ext_dac_update_n(ext_dac_update_n));
	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			report_and_stop();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic upd_pulse();
		i_atuc_pins_model.drive_upd(1'b0);
		i_atuc_pins_model.drive_upd(1'b1);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		repeat (100000) @(posedge mclk);
		err_total++;
		report_and_stop();
	end
	initial begin
		reset_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= ATUC_OFS_CMD;
		pwdata <= 32'h0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, ATUC_OFS_CMD, 32'h0);
		chk("cmd reset", rdv, 32'h0);
		chk("irq reset", {31'h0, irq}, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped slverr", {31'h0, errv}, 32'h1);
		chk("unmapped data", rdv, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, ATUC_OFS_COUNT, m_cnt[i]);
			apb(1'b1, ATUC_OFS_CMD, {24'h0, m_cmd[i]});
			apb(1'b1, ATUC_OFS_ARM, 32'h0);
			base = conv_n;
			i_atuc_pins_model.conv_pulses(m_pre[i]);
			chk("pre conversions", conv_n - base, e_pre[i]);
			base = conv_n;
			if (m_low[i]) i_atuc_pins_model.drive_conv(1'b0);
			i_atuc_pins_model.drive_trig(1'b1);
			if (m_low[i]) i_atuc_pins_model.drive_conv(1'b1);
			i_atuc_pins_model.conv_pulses(4);
			i_atuc_pins_model.drive_trig(1'b0);
			i_atuc_pins_model.drive_trig(1'b1);
			i_atuc_pins_model.conv_pulses(4);
			i_atuc_pins_model.drive_trig(1'b0);
			chk("post conversions", conv_n - base, e_post[i]);
			$display("test mode %0d done", i);
		end
		apb(1'b1, ATUC_OFS_CMD, 32'h60);
		apb(1'b1, ATUC_OFS_DAC0, 32'hABC);
		apb(1'b1, ATUC_OFS_DAC1, 32'h456);
		i_atuc_pins_model.drive_upd(1'b1);
		chk("dac0 held", {20'h0, dac0_out}, 32'h0);
		i_atuc_pins_model.drive_upd(1'b0);
		chk("dac0 loaded", {20'h0, dac0_out}, 32'hABC);
		chk("dac1 loaded", {20'h0, dac1_out}, 32'h456);
		apb(1'b1, ATUC_OFS_DAC0, 32'h123);
		i_atuc_pins_model.drive_upd(1'b0);
		chk("dac0 direct", {20'h0, dac0_out}, 32'h123);
		i_atuc_pins_model.drive_upd(1'b1);
		apb(1'b1, ATUC_OFS_DAC0, 32'h777);
		i_atuc_pins_model.drive_upd(1'b1);
		chk("dac0 after high", {20'h0, dac0_out}, 32'h123);
		$display("test dac done");
		apb(1'b1, ATUC_OFS_MASK, 32'h1);
		apb(1'b1, ATUC_OFS_STATUS, 32'hF);
		apb(1'b1, ATUC_OFS_CMD, 32'h80);
		apb(1'b0, ATUC_OFS_STATUS, 32'h0);
		chk("flag cleared", rdv & 32'h1, 32'h0);
		upd_pulse();
		apb(1'b0, ATUC_OFS_STATUS, 32'h0);
		chk("flag set", rdv & 32'h1, 32'h1);
		chk("irq enabled", {31'h0, irq}, 32'h1);
		apb(1'b1, ATUC_OFS_MASK, 32'h0);
		apb(1'b0, ATUC_OFS_STATUS, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, ATUC_OFS_MASK, 32'h1);
		apb(1'b1, ATUC_OFS_TMR_CLR, 32'h0);
		apb(1'b0, ATUC_OFS_STATUS, 32'h0);
		chk("flag timer clear", rdv & 32'h1, 32'h0);
		chk("irq timer clear", {31'h0, irq}, 32'h0);
		apb(1'b1, ATUC_OFS_CMD, 32'h0);
		upd_pulse();
		apb(1'b0, ATUC_OFS_STATUS, 32'h0);
		chk("flag unenabled", rdv & 32'h1, 32'h1);
		chk("irq unenabled", {31'h0, irq}, 32'h0);
		$display("test irq done");
		report_and_stop();
	end
endmodule
`default_nettype wire
